// *** include/ivt_pkg.sv ***
`default_nettype none
package ivt_pkg;
  localparam int NUM_INT    = 54;
  localparam int PRIO_REGS  = 14;
  localparam int VEC_OFFSET = 8;
  // Reserved numbers 4,15,23-26,28,33-36,43-53
  localparam logic [53:0] RESERVED_MASK = 54'h3ff81e17808010;
  localparam int SRC_CMP_FIRST      = 29;
  localparam int SRC_ADC_PAIR_FIRST = 37;

  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_PRIO_BASE = 5'h01;
  localparam logic [4:0] ADDR_STATUS    = 5'h0f;

  localparam int BIT_NEST   = 15;
  localparam int BIT_OVA    = 14;
  localparam int BIT_OVB    = 13;
  localparam int BIT_COVA   = 12;
  localparam int BIT_COVB   = 11;
  localparam int BIT_OVA_EN = 10;
  localparam int BIT_OVB_EN = 9;
  localparam int BIT_COV_EN = 8;
  localparam int BIT_SHIFT  = 7;
  localparam int BIT_ARITH  = 6;
  localparam int BIT_MATH   = 4;
  localparam int BIT_ADDR   = 3;
  localparam int BIT_STACK  = 2;
  localparam int BIT_CLKF   = 1;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hffde;
  localparam logic [15:0] RD_ZERO    = 16'h0000;

  localparam int STAT_VALID = 15;
  localparam int STAT_LEVEL = 8;
endpackage
`default_nettype wire

// *** rtl/ivt_ctrl.sv ***
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module ivt_ctrl #(
  parameter int LEVEL_BITS = 3
) (
  input  wire  logic        SYS_CLK,
  input  wire  logic        NRST,
  input  wire  logic [4:0]  REG_ADDR,
  input  wire  logic [15:0] REG_WDATA,
  input  wire  logic        REG_WR,
  input  wire  logic        REG_RD,
  output var   logic [15:0] REG_RDATA,
  input  wire  logic [53:0] IRQ_REQ,
  input  wire  logic [2:0]  CPU_PRIORITY,
  input  wire  logic        CPU_HANDLER_ACTIVE,
  input  wire  logic        TRAP_ACC_A_OVF,
  input  wire  logic        TRAP_ACC_B_OVF,
  input  wire  logic        TRAP_ACC_A_CAT,
  input  wire  logic        TRAP_ACC_B_CAT,
  input  wire  logic        TRAP_SHIFT_ERR,
  input  wire  logic        TRAP_ARITH_ERR,
  input  wire  logic        TRAP_ADDR_ERR,
  input  wire  logic        TRAP_STACK_ERR,
  input  wire  logic        TRAP_CLOCK_FAIL,
  output var   logic        VEC_VALID,
  output var   logic [5:0]  VEC_NUM,
  output var   logic [2:0]  VEC_LEVEL,
  output var   logic        MATH_TRAP,
  output var   logic        NESTING_DISABLE
);

  if (LEVEL_BITS != 3) begin : g_chk
    $error("Level field must be 3 bits wide");
  end

  logic [15:0]           core_trap_control;
  logic [15:0]           next_ctrl;
  logic [15:0]           ctrl_set;
  logic [LEVEL_BITS-1:0] prio [ivt_pkg::NUM_INT];
  wire  logic [223:0]    prio_flat;
  logic [53:0]           req_eff;
  logic                  found;
  logic [5:0]            best_src;
  logic [2:0]            best_lvl;
  logic                  take;
  logic [5:0]            win_src;
  logic [15:0]           next_rdata;
  logic                  ctrl_wr;
  logic                  math_set;
  logic                  outranked;

  assign ctrl_wr = REG_WR && (REG_ADDR == ivt_pkg::ADDR_CTRL);

  // Reserved slots never request
  assign req_eff = IRQ_REQ & ~ivt_pkg::RESERVED_MASK;

  // Comparators at 29..32, ADC pairs at 37..42
  if (ivt_pkg::SRC_CMP_FIRST + 3 != 32) begin : g_cmp
    $error("Comparator block misplaced");
  end
  if (ivt_pkg::SRC_ADC_PAIR_FIRST + 5 != 42) begin : g_adc
    $error("ADC pair block misplaced");
  end

  // Per-source level storage, four nibbles per register
  for (genvar i = 0; i < ivt_pkg::NUM_INT; i++) begin : g_src
    localparam logic [4:0] PADDR = ivt_pkg::ADDR_PRIO_BASE + 5'(i / 4);
    localparam int         NIB   = 4 * (i % 4);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
        prio[i] <= '0;
      end else if (REG_WR && REG_ADDR == PADDR &&
                   !ivt_pkg::RESERVED_MASK[i]) begin
        prio[i] <= REG_WDATA[NIB +: LEVEL_BITS];
      end
    end

    // Bit 3 of each nibble reads zero
    assign prio_flat[4*i +: 4] = {1'b0, prio[i]};
  end
  assign prio_flat[223:216] = 8'h00;

  // Highest level wins; lowest number wins a tie
  always_comb begin
    found    = 1'b0;
    best_src = 6'h00;
    best_lvl = 3'h0;
    for (int i = ivt_pkg::NUM_INT - 1; i >= 0; i--) begin
      if (req_eff[i] && (!found || prio[i] >= best_lvl)) begin
        found    = 1'b1;
        best_src = 6'(i);
        best_lvl = prio[i];
      end
    end
  end

  // Offer only above core level; hold off in a handler while nested handling off
  assign take = found && (best_lvl > CPU_PRIORITY) &&
                !(core_trap_control[ivt_pkg::BIT_NEST] &&
                  CPU_HANDLER_ACTIVE);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      VEC_VALID <= 1'b0;
      VEC_NUM   <= 6'h00;
      VEC_LEVEL <= 3'h0;
      win_src   <= 6'h00;
    end else begin
      VEC_VALID <= take;
      VEC_NUM   <= best_src + 6'(ivt_pkg::VEC_OFFSET);
      VEC_LEVEL <= best_lvl;
      win_src   <= best_src;
    end
  end

  // Hardware set sources; only the four accumulator flags are gated by their trap enables
  always_comb begin
    ctrl_set = 16'h0000;
    ctrl_set[ivt_pkg::BIT_OVA]   = TRAP_ACC_A_OVF &&
      core_trap_control[ivt_pkg::BIT_OVA_EN];
    ctrl_set[ivt_pkg::BIT_OVB]   = TRAP_ACC_B_OVF &&
      core_trap_control[ivt_pkg::BIT_OVB_EN];
    ctrl_set[ivt_pkg::BIT_COVA]  = TRAP_ACC_A_CAT &&
      core_trap_control[ivt_pkg::BIT_COV_EN];
    ctrl_set[ivt_pkg::BIT_COVB]  = TRAP_ACC_B_CAT &&
      core_trap_control[ivt_pkg::BIT_COV_EN];
    ctrl_set[ivt_pkg::BIT_SHIFT] = TRAP_SHIFT_ERR;
    ctrl_set[ivt_pkg::BIT_ARITH] = TRAP_ARITH_ERR;
    ctrl_set[ivt_pkg::BIT_MATH]  = |ctrl_set[15:6];
    ctrl_set[ivt_pkg::BIT_ADDR]  = TRAP_ADDR_ERR;
    ctrl_set[ivt_pkg::BIT_STACK] = TRAP_STACK_ERR;
    ctrl_set[ivt_pkg::BIT_CLKF]  = TRAP_CLOCK_FAIL;
  end

  assign math_set = ctrl_set[ivt_pkg::BIT_MATH];

  // A hardware set wins over a software clear in the same cycle
  always_comb begin
    if (ctrl_wr) begin
      next_ctrl = (REG_WDATA & ivt_pkg::CTRL_WMASK) | ctrl_set;
    end else begin
      next_ctrl = core_trap_control | ctrl_set;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      core_trap_control <= ivt_pkg::CTRL_RESET;
    end else begin
      core_trap_control <= next_ctrl;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      MATH_TRAP <= 1'b0;
    end else begin
      MATH_TRAP <= math_set;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      NESTING_DISABLE <= 1'b0;
    end else begin
      NESTING_DISABLE <= next_ctrl[ivt_pkg::BIT_NEST];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = ivt_pkg::RD_ZERO;
    if (REG_ADDR == ivt_pkg::ADDR_CTRL) begin
      next_rdata = core_trap_control & ivt_pkg::CTRL_WMASK;
    end else if (REG_ADDR == ivt_pkg::ADDR_STATUS) begin
      next_rdata[ivt_pkg::STAT_VALID] = VEC_VALID;
      next_rdata[ivt_pkg::STAT_LEVEL +: 3] = VEC_LEVEL;
      next_rdata[5:0] = VEC_NUM;
    end else if (REG_ADDR >= ivt_pkg::ADDR_PRIO_BASE &&
                 REG_ADDR < ivt_pkg::ADDR_PRIO_BASE +
                            5'(ivt_pkg::PRIO_REGS)) begin
      next_rdata = prio_flat[16 *
        (4'(REG_ADDR - ivt_pkg::ADDR_PRIO_BASE)) +: 16];
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= ivt_pkg::RD_ZERO;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= ivt_pkg::RD_ZERO;
    end
  end

  // Check helper: a pending source that should have beaten the winner
  always_comb begin
    outranked = 1'b0;
    for (int j = 0; j < ivt_pkg::NUM_INT; j++) begin
      if (req_eff[j] && found) begin
        if (prio[j] > best_lvl) begin
          outranked = 1'b1;
        end
        if (prio[j] == best_lvl && 6'(j) < best_src) begin
          outranked = 1'b1;
        end
      end
    end
  end

  // Checks

  vec_offset_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    VEC_VALID |-> VEC_NUM == win_src + 6'd8)
    else $error("Vector not number plus eight");

  tie_order_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    !outranked)
    else $error("Wrong winner among pending sources");

  win_order_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    take |=> VEC_VALID && win_src == $past(best_src))
    else $error("Winner not presented next cycle");

  rsv_silent_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    VEC_VALID |-> !ivt_pkg::RESERVED_MASK[win_src])
    else $error("Reserved slot presented a vector");

  nest_block_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    core_trap_control[15] && CPU_HANDLER_ACTIVE |=> !VEC_VALID)
    else $error("Preempted with nesting disabled");

  level_gate_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    VEC_VALID |-> VEC_LEVEL > $past(CPU_PRIORITY))
    else $error("Vector at or below core level");

  ova_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    TRAP_ACC_A_OVF && core_trap_control[10]
      |=> core_trap_control[14] && MATH_TRAP)
    else $error("Overflow A flag not set");

  ovb_gate_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    !core_trap_control[9] && !ctrl_wr
      |=> $stable(core_trap_control[13]))
    else $error("Overflow B flag moved while disabled");

  covb_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    TRAP_ACC_B_CAT && core_trap_control[8]
      |=> core_trap_control[11] && core_trap_control[4])
    else $error("Catastrophic B flag not set");

  cova_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    TRAP_ACC_A_CAT && core_trap_control[8] |=> core_trap_control[12])
    else $error("Catastrophic A flag not set");

  cov_gate_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    !core_trap_control[8] && !ctrl_wr
      |=> $stable(core_trap_control[12:11]))
    else $error("Catastrophic flag moved while disabled");

  shift_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    TRAP_SHIFT_ERR |=> core_trap_control[7] && core_trap_control[4])
    else $error("Shift error flag not set");

  arith_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    TRAP_ARITH_ERR |=> core_trap_control[6] && MATH_TRAP)
    else $error("Arithmetic error flag not set");

  math_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    $rose(core_trap_control[4])
      |-> $past(math_set || (ctrl_wr && REG_WDATA[4])))
    else $error("Math flag set without cause");

  addr_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    TRAP_ADDR_ERR |=> core_trap_control[3])
    else $error("Address error flag not set");

  stack_clk_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    ctrl_wr && !TRAP_STACK_ERR && !TRAP_CLOCK_FAIL
      |=> core_trap_control[2:1] == $past(REG_WDATA[2:1]))
    else $error("Stack or clock flag not writable");

  ctrl_zero_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    REG_RD && REG_ADDR == 5'h00 |=> !REG_RDATA[5] && !REG_RDATA[0])
    else $error("Unimplemented bits read nonzero");

  prio_read_a: assert property (@(posedge SYS_CLK)
    disable iff (!NRST)
    REG_RD && REG_ADDR == 5'h01 |=> REG_RDATA[3:0] == {1'b0, prio[0]})
    else $error("Level readback mismatch");

endmodule
`default_nettype wire

// *** verification/ivt_core_model.sv ***
`default_nettype none
module ivt_core_model (
  input  wire logic [53:0] set_req,
  input  wire logic [2:0]  set_prio,
  input  wire logic        set_act,
  output var  logic [53:0] irq_req,
  output var  logic [2:0]  cpu_priority,
  output var  logic        handler_active
);
  // Sources hold levels; reserved lines may toggle as well
  always_comb begin
    irq_req        = set_req;
    cpu_priority   = set_prio;
    handler_active = set_act;
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [53:0] req = '0;
  logic [2:0]  prio = 3'h0;
  logic        act = 1'b0;
  logic [8:0]  trap = '0;
  logic [53:0] irq;
  logic [2:0]  cpu_prio;
  logic        cpu_act;
  logic        vvalid;
  logic        mtrap;
  logic        nest_o;
  logic [5:0]  vnum;
  logic [2:0]  vlvl;
  logic [2:0]  lvl [54];
  logic [31:0] seed = 32'h5;
  logic        nest = 1'b0;
  int          failures = 0;
  int          cmp_count = 0;
  int          tbit [9] = '{14, 13, 12, 11, 7, 6, 3, 2, 1};

  ivt_core_model partner (.set_req(req), .set_prio(prio), .set_act(act),
    .irq_req(irq), .cpu_priority(cpu_prio), .handler_active(cpu_act));
  ivt_ctrl #(.LEVEL_BITS(3)) uut (
    .SYS_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ_REQ(irq),
    .CPU_PRIORITY(cpu_prio), .CPU_HANDLER_ACTIVE(cpu_act),
    .TRAP_ACC_A_OVF(trap[0]), .TRAP_ACC_B_OVF(trap[1]),
    .TRAP_ACC_A_CAT(trap[2]), .TRAP_ACC_B_CAT(trap[3]),
    .TRAP_SHIFT_ERR(trap[4]), .TRAP_ARITH_ERR(trap[5]),
    .TRAP_ADDR_ERR(trap[6]), .TRAP_STACK_ERR(trap[7]),
    .TRAP_CLOCK_FAIL(trap[8]), .VEC_VALID(vvalid), .VEC_NUM(vnum),
    .VEC_LEVEL(vlvl), .MATH_TRAP(mtrap), .NESTING_DISABLE(nest_o));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] lvl_word(int r);
    logic [15:0] w;
    w = 16'h0000;
    for (int k = 0; k < 4; k++)
      if (4 * r + k < 54) w[4*k +: 3] = lvl[4*r + k];
    return w;
  endfunction

  // Highest level wins; strict compare keeps the lowest number on ties
  function automatic logic [15:0] exp_vec();
    logic [2:0] bl;
    int         bn;
    bl = 3'h0;
    bn = 0;
    for (int n = 0; n < 54; n++)
      if (req[n] && !ivt_pkg::RESERVED_MASK[n] && lvl[n] > bl) begin
        bl = lvl[n];
        bn = n;
      end
    if (bl <= prio || (nest && act)) return 16'h0000;
    return {1'b1, 4'h0, bl, 2'h0, 6'(bn + 8)};
  endfunction

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wr_lvl(input int r, input logic [15:0] d);
    int n;
    wr_reg(ivt_pkg::ADDR_PRIO_BASE + 5'(r), d);
    for (int k = 0; k < 4; k++) begin
      n = 4 * r + k;
      if (n < 54) lvl[n] = ivt_pkg::RESERVED_MASK[n] ? 3'h0 : d[4*k +: 3];
    end
  endtask

  task automatic drive_chk(input logic [53:0] r, input logic [2:0] p,
                           input logic a);
    logic [15:0] s;
    @(posedge clk);
    req  <= r;
    prio <= p;
    act  <= a;
    @(posedge clk);
    #1 s = {vvalid, 4'h0, vlvl & {3{vvalid}}, 2'h0, vnum & {6{vvalid}}};
    chk(s, exp_vec());
  endtask

  task automatic trap_pulse(input int i, input logic [15:0] en,
                            input logic [15:0] exp, input logic m);
    logic [15:0] d;
    wr_reg(ivt_pkg::ADDR_CTRL, en);
    @(posedge clk);
    trap[i] <= 1'b1;
    @(posedge clk);
    trap[i] <= 1'b0;
    #1 chk({15'h0, mtrap}, {15'h0, m});
    rd_reg(ivt_pkg::ADDR_CTRL, d);
    chk(d, exp);
  endtask

  initial begin
    logic [15:0] d;
    logic [15:0] e;
    foreach (lvl[n]) lvl[n] = 3'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(ivt_pkg::ADDR_CTRL, d);
    chk(d, 16'h0000);
    wr_reg(ivt_pkg::ADDR_CTRL, 16'hffff);
    rd_reg(ivt_pkg::ADDR_CTRL, d);
    chk(d, 16'hffde);
    @(posedge clk);
    #1 chk({rdata[15:1], nest_o}, 16'h0001);
    wr_reg(5'h1f, 16'hffff);
    rd_reg(5'h1f, d);
    chk(d, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      e = 16'h0700 | (16'h1 << tbit[i]) | (i < 6 ? 16'h0010 : 16'h0000);
      trap_pulse(i, 16'h0700, e, i < 6);
    end
    trap_pulse(0, 16'h0000, 16'h0000, 1'b0);
    trap_pulse(3, 16'h0600, 16'h0600, 1'b0);
    wr_reg(ivt_pkg::ADDR_CTRL, 16'h0000);
    for (int r = 0; r < 14; r++) wr_lvl(r, 16'h7777);
    for (int n = 0; n < 54; n++) drive_chk(54'h1 << n, 3'h0, 1'b0);
    drive_chk('1, 3'h6, 1'b0);
    rd_reg(ivt_pkg::ADDR_STATUS, d);
    chk(d, exp_vec());
    drive_chk('1, 3'h7, 1'b0);
    wr_reg(ivt_pkg::ADDR_CTRL, 16'h8000);
    nest = 1'b1;
    drive_chk('1, 3'h0, 1'b1);
    drive_chk('1, 3'h0, 1'b0);
    for (int it = 0; it < 300; it++) begin
      if (it % 30 == 0) begin
        for (int r = 0; r < 14; r++) begin
          wr_lvl(r, 16'(xs()));
          rd_reg(ivt_pkg::ADDR_PRIO_BASE + 5'(r), d);
          chk(d, lvl_word(r));
        end
        d = 16'(xs());
        nest = d[0];
        wr_reg(ivt_pkg::ADDR_CTRL, {nest, 15'h0000});
      end
      drive_chk(54'({xs(), xs()} & {xs(), xs()}), 3'(xs()), 1'(xs()));
    end
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
